// File: common/ace_pkg.sv
// package for the comparator event control block
// assumes a 32-bit APB slave with word-aligned registers
`default_nettype none
package ace_pkg;

	// register byte addresses
	localparam logic [11:0] ACE_OFF_STATUS_CONTROL = 12'h000; // the single 8-bit control/status register
	localparam logic [11:0] ACE_OFF_IRQ_STATUS     = 12'h004; // sticky event status, write one to clear
	localparam logic [11:0] ACE_OFF_IRQ_MASK       = 12'h008; // interrupt mask, same layout as status

	// field positions in status_control_reg
	localparam int ACE_BIT_ENABLE   = 7;
	localparam int ACE_BIT_BANDGAP  = 6;
	localparam int ACE_BIT_FLAG     = 5;
	localparam int ACE_BIT_IRQ_EN   = 4;
	localparam int ACE_BIT_LEVEL    = 3;
	localparam int ACE_BIT_PIN_EN   = 2;
	localparam int ACE_BIT_MODE_HI  = 1;
	localparam int ACE_BIT_MODE_LO  = 0;

	// layout of the event status and mask registers
	localparam int ACE_EV_COMPARE = 0; // compare event seen
	localparam int ACE_EV_RISE    = 1; // any rising edge
	localparam int ACE_EV_FALL    = 2; // any falling edge while enabled
	localparam int ACE_EV_W       = 3;

	// reset values
	localparam logic [7:0]          ACE_RST_CTRL = 8'h00;
	localparam logic [ACE_EV_W-1:0] ACE_RST_EV   = 3'h0;
	localparam logic [ACE_EV_W-1:0] ACE_RST_MASK = 3'h0;

	// event mode encodings
	typedef enum logic [1:0]
	{
		ACE_MODE_FALL0 = 2'h0,
		ACE_MODE_RISE  = 2'h1,
		ACE_MODE_FALL2 = 2'h2,
		ACE_MODE_BOTH  = 2'h3
	} ace_mode_t;

	// synchroniser depth
	localparam int ACE_SYNC_STAGES = 2;

endpackage
`default_nettype wire

// File: rtl/ace_sync.sv
// two-flop synchroniser for the asynchronous comparator level
// assumes the input comes from the analog comparator outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module ace_sync
	import ace_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_level,
	output var  logic sync_level
);

	logic meta_reg; // first stage, read only by the second

	// two stages, constant reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg   <= 1'b0;
			sync_level <= 1'b0;
		end
		else
		begin
			meta_reg   <= async_level;
			sync_level <= meta_reg;
		end
	end

endmodule
`default_nettype wire

// File: rtl/ace_top.sv
// comparator event control: enable, reference select, edge events, irq, output pin
// assumes an APB master on pclk and an asynchronous comparator result input
//
// Summary of operation
// - bit 7 enables the comparator unit
// - bit 6 picks pin or bandgap
// - flag sets on selected compare event
// - write one clears flag, zero keeps
// - irq while flag and irq enable
// - bit 3 reads comparator level, read-only
// - level reads zero while disabled
// - bit 2 drives level onto pin
// - mode: fall, rise, fall, either edge
// - high when plus exceeds minus input
// - all control but the event irq mask in one 8-bit register
// - keeps running in wait mode
// - stop mode events still set flag
// - deep stop wake gives reset state
// - runs normally during background debug
`timescale 1ns/1ps
`default_nettype none
module ace_top
	import ace_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        comparator_raw,
	output var  logic        comparator_power_en,
	output var  logic        bandgap_route,
	output var  logic        comparator_out_pin,
	output var  logic        comparator_out_pin_oe,
	output var  logic        irq,
	output var  logic        irq_summary
);
	import ace_pkg::*;

	logic [7:0]          ctrl_reg;     // writable control bits
	logic                flag_reg;     // compare_event_flag
	logic [ACE_EV_W-1:0] ev_reg;       // sticky event status
	logic [ACE_EV_W-1:0] mask_reg;     // interrupt mask
	logic                level_sync;   // synchronised comparator
	logic                level_prev_reg; // previous gated level
	logic                level_now;    // gated level
	logic                rise;
	logic                fall;
	logic                hit;
	logic                wr_acc;
	logic                rd_acc;
	logic                sel_ctrl;
	logic                sel_ev;
	logic                sel_mask;
	logic                flag_clr;
	logic [ACE_EV_W-1:0] ev_clr;
	logic [ACE_EV_W-1:0] ev_set;

	// decide whether an edge matches the selected mode
	function automatic logic mode_hit(input logic [1:0] m, input logic r, input logic f);
		logic h;
		h = 1'b0;
		case (ace_mode_t'(m))
			ACE_MODE_FALL0: h = f;
			ACE_MODE_RISE:  h = r;
			ACE_MODE_FALL2: h = f;
			ACE_MODE_BOTH:  h = r | f;
			default:        h = 1'b0;
		endcase
		return h;
	endfunction

	// the analog comparator itself outputs high when plus exceeds minus; we only sample it
	ace_sync u_sync
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.async_level (comparator_raw),
		.sync_level  (level_sync)
	);

	// level is forced low while the unit is off, so enabling with the comparator already high shows as a rise
	assign level_now = level_sync & ctrl_reg[ACE_BIT_ENABLE];
	assign rise      = level_now & ~level_prev_reg;
	assign fall      = ~level_now & level_prev_reg;
	// no gating by any low-power or debug state: the unit keeps running whenever enabled
	assign hit       = ctrl_reg[ACE_BIT_ENABLE] & mode_hit(ctrl_reg[1:0], rise, fall);

	// apb decode; zero-wait slave
	assign wr_acc   = psel & penable & pwrite;
	assign rd_acc   = psel & ~pwrite;
	assign sel_ctrl = (paddr == ACE_OFF_STATUS_CONTROL);
	assign sel_ev   = (paddr == ACE_OFF_IRQ_STATUS);
	assign sel_mask = (paddr == ACE_OFF_IRQ_MASK);
	assign flag_clr = wr_acc & sel_ctrl & pstrb[0] & pwdata[ACE_BIT_FLAG];
	assign ev_clr   = (wr_acc & sel_ev & pstrb[0]) ? pwdata[ACE_EV_W-1:0] : ACE_RST_EV;
	assign ev_set   = {fall & ctrl_reg[ACE_BIT_ENABLE], rise, hit};

	// previous level for edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level_prev_reg <= 1'b0;
		else
			level_prev_reg <= level_now;
	end

	// control bits; flag and level positions are not storage here
	// a deep-stop wake arrives as presetn, which returns everything to reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_reg <= ACE_RST_CTRL;
		else if (wr_acc & sel_ctrl & pstrb[0])
		begin
			ctrl_reg <= pwdata[7:0] & 8'hD7;
		end
	end

	// compare event flag: set wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_reg <= 1'b0;
		else if (hit)
			flag_reg <= 1'b1;
		else if (flag_clr)
			flag_reg <= 1'b0;
	end

	// sticky event status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ev_reg <= ACE_RST_EV;
		else
			ev_reg <= (ev_reg & ~ev_clr) | ev_set;
	end

	// interrupt mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_reg <= ACE_RST_MASK;
		else if (wr_acc & sel_mask & pstrb[0])
			mask_reg <= pwdata[ACE_EV_W-1:0];
	end

	// registered outputs to the analog side and pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			comparator_power_en   <= 1'b0;
			bandgap_route         <= 1'b0;
			comparator_out_pin    <= 1'b0;
			comparator_out_pin_oe <= 1'b0;
		end
		else
		begin
			comparator_power_en   <= ctrl_reg[ACE_BIT_ENABLE];
			bandgap_route         <= ctrl_reg[ACE_BIT_BANDGAP];
			comparator_out_pin    <= level_now & ctrl_reg[ACE_BIT_PIN_EN];
			comparator_out_pin_oe <= ctrl_reg[ACE_BIT_PIN_EN];
		end
	end

	// interrupt lines; one cycle later than the flag and the sticky status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq         <= 1'b0;
			irq_summary <= 1'b0;
		end
		else
		begin
			irq         <= flag_reg & ctrl_reg[ACE_BIT_IRQ_EN];
			irq_summary <= |(ev_reg & mask_reg);
		end
	end

	// apb read data captured in the setup cycle, ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~(sel_ctrl | sel_ev | sel_mask);
			if (rd_acc & ~penable)
			begin
				if (sel_ctrl)
					prdata <= {24'h00_0000, ctrl_reg[7:6], flag_reg, ctrl_reg[4], level_now, ctrl_reg[2:0]};
				else if (sel_ev)
					prdata <= {29'h0000_0000, ev_reg};
				else if (sel_mask)
					prdata <= {29'h0000_0000, mask_reg};
				else
					prdata <= 32'h0000_0000;
			end
		end
	end

	// flag follows a selected edge in the next cycle
	a_flag_on_hit: assert property (@(posedge pclk) disable iff (!presetn) hit |=> flag_reg)
		else $error("flag not set after event");

	// a one written clears the flag unless an event lands
	a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn) (flag_clr && !hit) |=> !flag_reg)
		else $error("flag not cleared by write one");

	// flag stays set without a clear
	a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) (flag_reg && !flag_clr) |=> flag_reg)
		else $error("flag lost without clear");

	// irq follows flag and enable
	a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) irq == $past(flag_reg & ctrl_reg[ACE_BIT_IRQ_EN]))
		else $error("irq does not follow flag and enable");

	// disabled unit never reports a level nor events
	a_level_off: assert property (@(posedge pclk) disable iff (!presetn) !ctrl_reg[ACE_BIT_ENABLE] |-> (!level_now && !hit))
		else $error("level or event while disabled");

	// rising mode: a two-cycle-old low then high sets the flag
	sequence s_rise_seen;
		(ctrl_reg[ACE_BIT_ENABLE] && ctrl_reg[1:0] == 2'h1 && !level_now) ##1 (level_now && ctrl_reg[1:0] == 2'h1);
	endsequence
	a_mode_rise: assert property (@(posedge pclk) disable iff (!presetn) s_rise_seen |=> flag_reg)
		else $error("rising edge missed");

	// falling-only modes ignore rises
	a_mode_norise: assert property (@(posedge pclk) disable iff (!presetn) (rise && !ctrl_reg[0]) |-> !hit)
		else $error("rise taken in falling mode");

	// pin shows level only when enabled
	a_pin_gate: assert property (@(posedge pclk) disable iff (!presetn) comparator_out_pin |-> comparator_out_pin_oe)
		else $error("pin driven while disabled");

	// setup phase of one register transfer, and a read of the control register
	sequence s_apb_setup;
		psel && !penable;
	endsequence
	sequence s_ctrl_read;
		s_apb_setup ##0 (!pwrite && sel_ctrl);
	endsequence

	// a zero-wait slave answers in the cycle after setup
	a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn) s_apb_setup |=> pready)
		else $error("ready missing after setup");

	// ready stands one cycle, so a held request is never taken twice
	a_apb_pulse: assert property (@(posedge pclk) disable iff (!presetn) pready |=> !pready)
		else $error("ready held longer than one cycle");

	// the error response only ever rides with ready
	a_apb_err: assert property (@(posedge pclk) disable iff (!presetn) pslverr |-> pready)
		else $error("error response without ready");

	// readback shows the gated level as it stood at setup
	a_read_level: assert property (@(posedge pclk) disable iff (!presetn)
		s_ctrl_read |=> prdata[ACE_BIT_LEVEL] == $past(level_now))
		else $error("level readback differs");

	// readback shows the flag as it stood at setup
	a_read_flag: assert property (@(posedge pclk) disable iff (!presetn)
		s_ctrl_read |=> prdata[ACE_BIT_FLAG] == $past(flag_reg))
		else $error("flag readback differs");

	// a disabled unit reads its level as zero
	a_read_off: assert property (@(posedge pclk) disable iff (!presetn)
		(s_ctrl_read ##0 !ctrl_reg[ACE_BIT_ENABLE]) |=> !prdata[ACE_BIT_LEVEL])
		else $error("level read as one while disabled");

	// analog controls follow the register one cycle later
	a_power_follow: assert property (@(posedge pclk) disable iff (!presetn)
		comparator_power_en == $past(ctrl_reg[ACE_BIT_ENABLE]))
		else $error("comparator power does not follow enable");

	a_route_follow: assert property (@(posedge pclk) disable iff (!presetn)
		bandgap_route == $past(ctrl_reg[ACE_BIT_BANDGAP]))
		else $error("reference route does not follow select");

	// the pin carries the enabled level only while its enable is set
	a_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
		comparator_out_pin == $past(level_sync & ctrl_reg[ACE_BIT_ENABLE] & ctrl_reg[ACE_BIT_PIN_EN]))
		else $error("pin level does not follow comparator");

	// either-edge mode takes both directions; a fall caused by disabling is no event
	a_mode_both: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_reg[ACE_BIT_ENABLE] && ctrl_reg[1:0] == 2'h3 && (rise || fall)) |=> flag_reg)
		else $error("edge missed in either-edge mode");

	// falling modes: an enabled high then low sets the flag
	sequence s_fall_high;
		ctrl_reg[ACE_BIT_ENABLE] && !ctrl_reg[ACE_BIT_MODE_LO] && level_now;
	endsequence
	sequence s_fall_low;
		ctrl_reg[ACE_BIT_ENABLE] && !ctrl_reg[ACE_BIT_MODE_LO] && !level_now;
	endsequence
	a_mode_fall: assert property (@(posedge pclk) disable iff (!presetn)
		s_fall_high ##1 s_fall_low |=> flag_reg)
		else $error("falling edge missed");

	// every selected event is also logged in the sticky status
	a_ev_compare: assert property (@(posedge pclk) disable iff (!presetn) hit |=> ev_reg[ACE_EV_COMPARE])
		else $error("compare event not logged");

endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the comparator event control block
// assumes ace_pkg is compiled first; drives the APB port and the raw comparator level itself
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ace_pkg::*;

	// one row: access, strobes, data, expected read data and error
	typedef struct packed
	{
		logic        w;
		logic [11:0] a;
		logic [7:0]  d;
		logic [3:0]  s;
		logic [7:0]  x;
		logic        e;
	} ace_row_t;

	logic        pclk;                  // 125 MHz bus clock
	logic        presetn;               // async reset, active low
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        comparator_raw;        // stands in for the analog result
	logic        comparator_power_en;
	logic        bandgap_route;
	logic        comparator_out_pin;
	logic        comparator_out_pin_oe;
	logic        irq;
	logic        irq_summary;
	int          mismatches;
	int          checked;
	int          i;
	int          m;
	logic        f;
	logic [31:0] r;
	logic        e;
	ace_row_t    rows [12];

	ace_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .comparator_raw(comparator_raw), .comparator_power_en(comparator_power_en),
		.bandgap_route(bandgap_route), .comparator_out_pin(comparator_out_pin),
		.comparator_out_pin_oe(comparator_out_pin_oe), .irq(irq), .irq_summary(irq_summary));

	// free-running clock, 8 ns period
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// compare and count; a mismatch is reported at once
	task chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x)
		begin
			$display("Error at %0t: got %h expected %h", $time, g, x);
			mismatches++;
		end
	endtask

	// one APB transfer; entered just after a rising edge, leaves one idle edge after release
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// no assumed wait count: only the watchdog ends a hung transfer
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		// answer taken at the edge where pready is sampled high
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d}, 4'hF);
	endtask

	task rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 32'h0, 4'hF);
		chk(r, {24'h0, x});
	endtask

	task wt(input int k);
		repeat (k) @(posedge pclk);
	endtask

	task conclude;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// watchdog: the whole run needs well under a thousand cycles
	initial
	begin
		#100000;
		mismatches++;
		conclude();
	end

	initial
	begin
		rows = '{
			'{1'b0, 12'h000, 8'h00, 4'hF, 8'h00, 1'b0},
			'{1'b0, 12'h004, 8'h00, 4'hF, 8'h00, 1'b0},
			'{1'b0, 12'h008, 8'h00, 4'hF, 8'h00, 1'b0},
			'{1'b1, 12'h000, 8'h57, 4'hF, 8'h00, 1'b0},
			'{1'b0, 12'h000, 8'h00, 4'hF, 8'h57, 1'b0},
			'{1'b1, 12'h000, 8'h00, 4'h0, 8'h00, 1'b0},
			'{1'b0, 12'h000, 8'h00, 4'hF, 8'h57, 1'b0},
			'{1'b1, 12'h008, 8'h07, 4'hF, 8'h00, 1'b0},
			'{1'b0, 12'h008, 8'h00, 4'hF, 8'h07, 1'b0},
			'{1'b0, 12'h00C, 8'h00, 4'hF, 8'h00, 1'b1},
			'{1'b1, 12'h00C, 8'hFF, 4'hF, 8'h00, 1'b1},
			'{1'b1, 12'h000, 8'h00, 4'hF, 8'h00, 1'b0}};
		{psel, penable, pwrite, paddr, pwdata, pstrb, comparator_raw} = '0;
		mismatches = 0;
		checked = 0;
		presetn = 1'b0;
		wt(10);
		presetn <= 1'b1;
		wt(1);
		// table: reset values, strobe, level read as zero while disabled, unmapped place
		for (i = 0; i < 12; i++)
		begin
			apb(rows[i].w, rows[i].a, {24'h0, rows[i].d}, rows[i].s);
			if (!rows[i].w)
				chk(r, {24'h0, rows[i].x});
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		$display("table test done");
		// every event mode, both edges, irq enabled
		for (m = 0; m < 4; m++)
		begin
			wr(12'h000, {6'b101100, m[1:0]});
			comparator_raw <= 1'b1;
			wt(6);
			f = (m == 1 || m == 3);
			rd(12'h000, {2'b10, f, 3'b110, m[1:0]});
			chk({31'h0, irq}, {31'h0, f});
			wr(12'h000, {6'b101100, m[1:0]});
			comparator_raw <= 1'b0;
			wt(6);
			f = (m != 1);
			rd(12'h000, {2'b10, f, 3'b100, m[1:0]});
			chk({31'h0, irq}, {31'h0, f});
			wr(12'h000, {6'b100100, m[1:0]});
			rd(12'h000, {2'b10, f, 3'b100, m[1:0]});
		end
		$display("mode test done");
		// sticky event status, mask and summary interrupt
		rd(12'h004, 8'h07);
		chk({31'h0, irq_summary}, 32'h1);
		wr(12'h004, 8'h07);
		wt(2);
		rd(12'h004, 8'h00);
		chk({31'h0, irq_summary}, 32'h0);
		wr(12'h008, 8'h00);
		comparator_raw <= 1'b1;
		wt(6);
		chk({31'h0, irq_summary}, 32'h0);
		rd(12'h004, 8'h03);
		// flag kept with irq enable off: no request
		wr(12'h000, 8'h83);
		wt(2);
		chk({31'h0, irq}, 32'h0);
		rd(12'h000, 8'hAB);
		// pin driven while enabled, bandgap off
		wr(12'h000, 8'h87);
		wt(2);
		chk({28'h0, comparator_power_en, bandgap_route, comparator_out_pin, comparator_out_pin_oe}, 32'hB);
		// disabled: level reads 0 and pin shows 0
		wr(12'h000, 8'h47);
		wt(2);
		rd(12'h000, 8'h67);
		chk({28'h0, comparator_power_en, bandgap_route, comparator_out_pin, comparator_out_pin_oe}, 32'h5);
		$display("output test done");
		// clear by a one while disabled-then-enabled with a low level
		comparator_raw <= 1'b0;
		wt(4);
		wr(12'h000, 8'hA1);
		rd(12'h000, 8'h81);
		// rise reaches the flag at the very edge where the clear lands: set wins
		comparator_raw <= 1'b1;
		wt(1);
		wr(12'h000, 8'hA1);
		rd(12'h000, 8'hA9);
		wr(12'h008, 8'h05);
		wt(2);
		chk({31'h0, irq_summary}, 32'h1);
		$display("set-wins test done");
		// second reset in mid-run clears everything
		presetn <= 1'b0;
		wt(2);
		presetn <= 1'b1;
		wt(1);
		chk({28'h0, comparator_power_en, bandgap_route, comparator_out_pin, comparator_out_pin_oe}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		chk({31'h0, irq_summary}, 32'h0);
		rd(12'h000, 8'h00);
		rd(12'h004, 8'h00);
		rd(12'h008, 8'h00);
		$display("reset test done");
		conclude();
	end
endmodule
`default_nettype wire
